// *** hdl/pio_regs.svh ***
// Register offsets, field positions and reset values of the parallel ports
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PIO_DIR1_OFS     12'h000
`define PIO_DIR2_OFS     12'h004
`define PIO_DATA1_OFS    12'h008
`define PIO_DATA2_OFS    12'h00c
`define PIO_DIR3_OFS     12'h010
`define PIO_DIR4_OFS     12'h014
`define PIO_DATA3_OFS    12'h018
`define PIO_DATA4_OFS    12'h01c
`define PIO_CSR3_OFS     12'h020
`define PIO_MODE_OFS     12'h024

// ----------------------------------------------------------------------
// Port 3 control field positions
// ----------------------------------------------------------------------
`define PIO_CSR3_OSS_BIT 3
`define PIO_CSR3_LE_BIT  4
`define PIO_CSR3_FLG_BIT 7

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define PIO_P2_WIDTH     5
`define PIO_DIR_RST      8'h00
`define PIO_DATA_RST     8'h00
`define PIO_CSR3_RST     8'h00

`endif

// *** hdl/pio_pkg.sv ***
// Types shared by the parallel port block
package pio_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    MODE_0 = 3'b000,
    MODE_1 = 3'b001,
    MODE_2 = 3'b010,
    MODE_3 = 3'b011,
    MODE_4 = 3'b100,
    MODE_5 = 3'b101,
    MODE_6 = 3'b110,
    MODE_7 = 3'b111
  } op_mode_t;

endpackage

// *** hdl/parallel_io_ports.sv ***
// Four parallel I/O ports with APB register access
// How it works
// - Three 8-bit ports plus one 5-bit port
// - Data and write-only direction register per port
// - Direction bit 0 input, 1 output
// - Data writes drive pins, reads return the latch on output bits, pins on input bits, or the port 3 capture latch while capture is enabled
// - Mode strap only reports pin ownership, no pins are remapped here
// - Capture enable 0 reads live pins
// - Strobe pulses on read or write per select
`timescale 1ns/100ps
`include "pio_regs.svh"

module parallel_io_ports
  import pio_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  mode_pins,
  output logic [2:0]       op_mode,
  output logic             port_mode_owned,
  input  wire logic [7:0]  port1_in,
  output logic [7:0]       port1_out,
  output logic [7:0]       port1_oe,
  input  wire logic [4:0]  port2_in,
  output logic [4:0]       port2_out,
  output logic [4:0]       port2_oe,
  input  wire logic [7:0]  port3_in,
  output logic [7:0]       port3_out,
  output logic [7:0]       port3_oe,
  input  wire logic        port3_input_strobe,
  output logic             port3_output_strobe_n,
  input  wire logic [7:0]  port4_in,
  output logic [7:0]       port4_out,
  output logic [7:0]       port4_oe
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [7:0]  p1_s1_ff, p1_s2_ff, p3_s1_ff, p3_s2_ff, p4_s1_ff, p4_s2_ff;
  logic [4:0]  p2_s1_ff, p2_s2_ff;
  logic [2:0]  md_s1_ff, md_s2_ff;
  logic        is_s1_ff, is_s2_ff, is_d_ff;
  logic [7:0]  nxt_p1_s1, nxt_p1_s2, nxt_p3_s1, nxt_p3_s2;
  logic [7:0]  nxt_p4_s1, nxt_p4_s2;
  logic [4:0]  nxt_p2_s1, nxt_p2_s2;
  logic [2:0]  nxt_md_s1, nxt_md_s2;
  logic        nxt_is_s1, nxt_is_s2, nxt_is_d;

  // Only the second stage is read by logic; the first may go metastable
  always_comb begin
    nxt_p1_s1 = port1_in;
    nxt_p1_s2 = p1_s1_ff;
    nxt_p2_s1 = port2_in;
    nxt_p2_s2 = p2_s1_ff;
    nxt_p3_s1 = port3_in;
    nxt_p3_s2 = p3_s1_ff;
    nxt_p4_s1 = port4_in;
    nxt_p4_s2 = p4_s1_ff;
    nxt_md_s1 = mode_pins;
    nxt_md_s2 = md_s1_ff;
    nxt_is_s1 = port3_input_strobe;
    nxt_is_s2 = is_s1_ff;
    nxt_is_d  = is_s2_ff;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      p1_s1_ff <= 8'h00;
      p1_s2_ff <= 8'h00;
      p2_s1_ff <= 5'h00;
      p2_s2_ff <= 5'h00;
      p3_s1_ff <= 8'h00;
      p3_s2_ff <= 8'h00;
      p4_s1_ff <= 8'h00;
      p4_s2_ff <= 8'h00;
      is_s1_ff <= 1'b1;
      is_s2_ff <= 1'b1;
      is_d_ff  <= 1'b1;
    end else begin
      p1_s1_ff <= nxt_p1_s1;
      p1_s2_ff <= nxt_p1_s2;
      p2_s1_ff <= nxt_p2_s1;
      p2_s2_ff <= nxt_p2_s2;
      p3_s1_ff <= nxt_p3_s1;
      p3_s2_ff <= nxt_p3_s2;
      p4_s1_ff <= nxt_p4_s1;
      p4_s2_ff <= nxt_p4_s2;
      is_s1_ff <= nxt_is_s1;
      is_s2_ff <= nxt_is_s2;
      is_d_ff  <= nxt_is_d;
    end
  end

  // Strap keeps flowing through reset, so it has settled at release
  always_ff @(posedge clk) begin
    md_s1_ff <= nxt_md_s1;
    md_s2_ff <= nxt_md_s2;
  end

  // Falling edge of the active-low input strobe
  logic is_fall;
  assign is_fall = is_d_ff & ~is_s2_ff;

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  byte_t      dir1_ff, dir3_ff, dir4_ff, nxt_dir1, nxt_dir3, nxt_dir4;
  byte_t      dat1_ff, dat3_ff, dat4_ff, nxt_dat1, nxt_dat3, nxt_dat4;
  logic [4:0] dir2_ff, dat2_ff, nxt_dir2, nxt_dat2;
  logic       oss_ff, nxt_oss, cap_en_ff, nxt_cap_en;
  logic       flag_ff, nxt_flag;
  byte_t      latch3_ff, nxt_latch3;
  logic       strb_ff, nxt_strb;
  op_mode_t   mode_ff, nxt_mode;
  logic       mode_taken_ff, nxt_mode_taken;
  logic [31:0] rdata_ff, nxt_rdata;

  // Writes and read side effects happen only at the access edge
  logic wr_acc, rd_acc, hit, dat3_hit;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;
  assign dat3_hit = (paddr == `PIO_DATA3_OFS);

  always_comb begin
    nxt_dir1   = dir1_ff;
    nxt_dir2   = dir2_ff;
    nxt_dir3   = dir3_ff;
    nxt_dir4   = dir4_ff;
    nxt_dat1   = dat1_ff;
    nxt_dat2   = dat2_ff;
    nxt_dat3   = dat3_ff;
    nxt_dat4   = dat4_ff;
    nxt_oss    = oss_ff;
    nxt_cap_en = cap_en_ff;
    nxt_rdata  = 32'h0000_0000;
    hit        = 1'b1;
    case (paddr)
      `PIO_DIR1_OFS, `PIO_DIR2_OFS, `PIO_DIR3_OFS, `PIO_DIR4_OFS: begin
        // Write-only: software must keep its own copy of the direction
        nxt_rdata = 32'h0000_0000;
        if (wr_acc) begin
          case (paddr)
            `PIO_DIR1_OFS: nxt_dir1 = pwdata[7:0];
            `PIO_DIR2_OFS: nxt_dir2 = pwdata[4:0];
            `PIO_DIR3_OFS: nxt_dir3 = pwdata[7:0];
            default:       nxt_dir4 = pwdata[7:0];
          endcase
        end
      end
      `PIO_DATA1_OFS: begin
        // Output bits read back the latch, input bits the pin
        nxt_rdata = {24'h0, (dat1_ff & dir1_ff) | (p1_s2_ff & ~dir1_ff)};
        if (wr_acc) nxt_dat1 = pwdata[7:0];
      end
      `PIO_DATA2_OFS: begin
        nxt_rdata = {27'h0, (dat2_ff & dir2_ff) | (p2_s2_ff & ~dir2_ff)};
        if (wr_acc) nxt_dat2 = pwdata[4:0];
      end
      `PIO_DATA3_OFS: begin
        nxt_rdata = {24'h0, (dat3_ff & dir3_ff) |
                     ((cap_en_ff ? latch3_ff : p3_s2_ff) & ~dir3_ff)};
        if (wr_acc) nxt_dat3 = pwdata[7:0];
      end
      `PIO_DATA4_OFS: begin
        nxt_rdata = {24'h0, (dat4_ff & dir4_ff) | (p4_s2_ff & ~dir4_ff)};
        if (wr_acc) nxt_dat4 = pwdata[7:0];
      end
      `PIO_CSR3_OFS: begin
        nxt_rdata = 32'h0;
        nxt_rdata[`PIO_CSR3_FLG_BIT] = flag_ff;
        nxt_rdata[`PIO_CSR3_OSS_BIT] = oss_ff;
        nxt_rdata[`PIO_CSR3_LE_BIT]  = cap_en_ff;
        if (wr_acc) begin
          nxt_oss    = pwdata[`PIO_CSR3_OSS_BIT];
          nxt_cap_en = pwdata[`PIO_CSR3_LE_BIT];
        end
      end
      `PIO_MODE_OFS: nxt_rdata = {29'h0, mode_ff};
      default: hit = 1'b0;
    endcase
    // Read data is frozen at the setup edge and stands through access
    if (!(psel && !penable)) nxt_rdata = rdata_ff;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dir1_ff   <= `PIO_DIR_RST;
      dir2_ff   <= 5'h00;
      dir3_ff   <= `PIO_DIR_RST;
      dir4_ff   <= `PIO_DIR_RST;
      dat1_ff   <= `PIO_DATA_RST;
      dat2_ff   <= 5'h00;
      dat3_ff   <= `PIO_DATA_RST;
      dat4_ff   <= `PIO_DATA_RST;
      oss_ff    <= 1'b0;
      cap_en_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      dir1_ff   <= nxt_dir1;
      dir2_ff   <= nxt_dir2;
      dir3_ff   <= nxt_dir3;
      dir4_ff   <= nxt_dir4;
      dat1_ff   <= nxt_dat1;
      dat2_ff   <= nxt_dat2;
      dat3_ff   <= nxt_dat3;
      dat4_ff   <= nxt_dat4;
      oss_ff    <= nxt_oss;
      cap_en_ff <= nxt_cap_en;
      rdata_ff  <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------------
  // Port 3 output strobe, capture latch and capture flag
  // --------------------------------------------------------------------
  always_comb begin
    nxt_strb   = 1'b0;
    nxt_flag   = flag_ff;
    nxt_latch3 = latch3_ff;
    // Capture on the input strobe only while capture is enabled
    if (cap_en_ff && is_fall) begin
      nxt_latch3 = p3_s2_ff;
    end
    // One-cycle pulse from a flop, so the strobe pin cannot glitch
    if (dat3_hit && rd_acc && !oss_ff) nxt_strb = 1'b1;
    if (dat3_hit && wr_acc && oss_ff) nxt_strb = 1'b1;
    // Reading port 3 data releases the capture flag
    if (dat3_hit && rd_acc) nxt_flag = 1'b0;
    // Set wins over the read clear, so no input strobe is lost
    if (is_fall) nxt_flag = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strb_ff   <= 1'b0;
      flag_ff   <= 1'b0;
      latch3_ff <= 8'h00;
    end else begin
      strb_ff   <= nxt_strb;
      flag_ff   <= nxt_flag;
      latch3_ff <= nxt_latch3;
    end
  end

  // --------------------------------------------------------------------
  // Operating mode strap
  // --------------------------------------------------------------------
  // Caught once, so a strap moving later cannot re-map pins mid-run
  always_comb begin
    nxt_mode       = mode_ff;
    nxt_mode_taken = 1'b1;
    if (!mode_taken_ff) begin
      nxt_mode = op_mode_t'(md_s2_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_ff       <= MODE_0;
      mode_taken_ff <= 1'b0;
    end else begin
      mode_ff       <= nxt_mode;
      mode_taken_ff <= nxt_mode_taken;
    end
  end

  // --------------------------------------------------------------------
  // APB answer: zero wait, read data from the setup cycle
  // --------------------------------------------------------------------
  // Refused offsets raise the error and leave all state alone
  // Slave answers in the first access cycle (zero wait)
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = rdata_ff;

  // --------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------
  // Mode-owned pins (ports 3 and 4 in expanded modes) would be taken by
  // the bus logic outside this block; here only the flag is reported.
  assign op_mode         = mode_ff;
  assign port_mode_owned = mode_taken_ff && (mode_ff != MODE_7) &&
                           (mode_ff != MODE_4);
  assign port1_out = dat1_ff;
  assign port1_oe  = dir1_ff;
  assign port2_out = dat2_ff;
  assign port2_oe  = dir2_ff;
  assign port3_out = dat3_ff;
  assign port3_oe  = dir3_ff;
  assign port4_out = dat4_ff;
  assign port4_oe  = dir4_ff;
  assign port3_output_strobe_n = ~strb_ff;

endmodule

// *** verif/pio_monitor.sv ***
// Concurrent checks on the parallel port block
`timescale 1ns/100ps
module pio_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [2:0]  op_mode,
  input wire logic        port_mode_owned,
  input wire logic [7:0]  port1_oe,
  input wire logic [7:0]  port1_out,
  input wire logic [4:0]  port2_oe,
  input wire logic [7:0]  port3_oe,
  input wire logic        port3_output_strobe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire wr = psel && penable && pwrite;
  sequence s_p3_acc;
    psel && penable && paddr == 12'h018;
  endsequence
  sequence s_pulse;
    s_p3_acc ##1 !port3_output_strobe_n;
  endsequence
  AST_STB_SRC: assert property (
    !port3_output_strobe_n |-> $past(psel && penable && paddr == 12'h018))
    else $error("strobe without port 3 access");
  AST_STB_ONE: assert property (s_pulse |=> port3_output_strobe_n)
    else $error("strobe longer than one cycle");
  AST_DIR_RD: assert property (psel && !penable && !pwrite &&
    paddr inside {12'h000, 12'h004, 12'h010, 12'h014} |=> prdata == 32'h0)
    else $error("direction register readable");
  AST_OE1: assert property (
    wr && paddr == 12'h000 |=> port1_oe == $past(pwdata[7:0]))
    else $error("port 1 direction not taken");
  AST_OE2: assert property (
    wr && paddr == 12'h004 |=> port2_oe == $past(pwdata[4:0]))
    else $error("port 2 direction not taken");
  AST_OUT1: assert property (
    wr && paddr == 12'h008 |=> port1_out == $past(pwdata[7:0]))
    else $error("port 1 data not driven");
  AST_RST_DIR: assert property (disable iff (1'b0)
    !reset_n |=> port1_oe == 8'h00 && port2_oe == 5'h00 && port3_oe == 8'h00)
    else $error("direction not cleared by reset");
  AST_MODE: assert property (
    reset_n && $past(reset_n) |->
      port_mode_owned == !(op_mode inside {3'h4, 3'h7}))
    else $error("mode ownership mismatch");
endmodule

bind parallel_io_ports pio_monitor mon (
  .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .op_mode, .port_mode_owned, .port1_oe, .port1_out, .port2_oe,
  .port3_oe, .port3_output_strobe_n
);

// *** verif/pio_pin_model.sv ***
// Peripheral pin model driving one port's input-side pins
`timescale 1ns/100ps
module pio_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] pin
);
  // Peripheral backs off wherever the port drives, so no contention
  assign pin = (oe & out) | (~oe & ext);
endmodule

// *** verif/parallel_io_ports_tb.sv ***
// Self-checking testbench of the parallel port block
`timescale 1ns/100ps
module parallel_io_ports_tb;
  import pio_pkg::*;
  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, serr, stb_n, owned, in_stb = 1;
  logic [2:0]  mode_pins = 3'h4, op_mode;
  byte_t       ext [4], out [4], oe [4], pin [4], d, v;
  logic [11:0] dir_a [4] = '{12'h000, 12'h004, 12'h010, 12'h014};
  logic [11:0] dat_a [4] = '{12'h008, 12'h00c, 12'h018, 12'h01c};
  byte_t       msk [4] = '{8'hff, 8'h1f, 8'hff, 8'hff};
  int          err_count = 0, check_count = 0, cyc = 0, stb_cnt = 0, c0, p;

  always #2 clk = ~clk;
  for (genvar g = 0; g < 4; g++) begin : g_pin
    pio_pin_model pm (.out(out[g]), .oe(oe[g]), .ext(ext[g]), .pin(pin[g]));
  end
  parallel_io_ports dut (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mode_pins, .op_mode, .port_mode_owned(owned),
    .port1_in(pin[0]), .port1_out(out[0]), .port1_oe(oe[0]),
    .port2_in(pin[1][4:0]), .port2_out(out[1][4:0]), .port2_oe(oe[1][4:0]),
    .port3_in(pin[2]), .port3_out(out[2]), .port3_oe(oe[2]),
    .port3_input_strobe(in_stb), .port3_output_strobe_n(stb_n),
    .port4_in(pin[3]), .port4_out(out[3]), .port4_oe(oe[3])
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input byte_t x);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, x};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [31:0] exp_pin(byte_t d, v, e, m);
    return {24'h0, ((d & v) | (~d & e)) & m};
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (stb_n === 1'b0) stb_cnt++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'h0069));
    foreach (ext[i]) ext[i] = 8'h00;
    repeat (4) @(posedge clk);
    reset_n <= 1;
    foreach (dir_a[i]) begin
      apb(0, dir_a[i], 8'hff);
      chk(rd, 0);
      chk(oe[i] & msk[i], 0);
    end
    $display("reset test done");
    // Random direction and data; capture is off so port 3 reads live pins
    for (int n = 0; n < 40; n++) begin
      p = $urandom_range(3);
      d = byte_t'($urandom);
      v = byte_t'($urandom);
      ext[p] <= byte_t'($urandom);
      apb(1, dir_a[p], d);
      apb(1, dat_a[p], v);
      chk(oe[p] & msk[p], d & msk[p]);
      repeat (3) @(posedge clk);
      chk(out[p] & msk[p], v & msk[p]);
      apb(0, dat_a[p], 0);
      chk(rd, exp_pin(d, v, ext[p], msk[p]));
    end
    $display("pin test done");
    for (int s = 0; s < 2; s++) begin
      apb(1, 12'h020, byte_t'(s << 3));
      c0 = stb_cnt;
      apb(0, 12'h018, 0);
      repeat (2) @(posedge clk);
      chk(stb_cnt - c0, s == 0);
      apb(1, 12'h018, 8'h3c);
      repeat (2) @(posedge clk);
      chk(stb_cnt - c0, 1);
    end
    $display("strobe test done");
    apb(1, 12'h010, 0);
    ext[2] <= 8'h5a;
    repeat (4) @(posedge clk);
    in_stb <= 0;
    repeat (3) @(posedge clk);
    in_stb <= 1;
    ext[2] <= 8'ha5;
    repeat (4) @(posedge clk);
    apb(0, 12'h018, 0);
    chk(rd, 32'ha5);
    // Capture enabled: reads return the value latched at the strobe
    apb(1, 12'h020, 8'h10);
    ext[2] <= 8'h3c;
    repeat (4) @(posedge clk);
    in_stb <= 0;
    repeat (3) @(posedge clk);
    in_stb <= 1;
    ext[2] <= 8'hc3;
    repeat (4) @(posedge clk);
    apb(0, 12'h020, 0);
    chk(rd, 32'h90);
    apb(0, 12'h018, 0);
    chk(rd, 32'h3c);
    apb(0, 12'h020, 0);
    chk(rd, 32'h10);
    apb(0, 12'h024, 0);
    chk(rd, 32'h4);
    chk(owned, 0);
    chk(op_mode, 3'h4);
    apb(0, 12'h030, 0);
    chk(serr, 1);
    $display("mode test done");
    apb(1, 12'h000, 8'hff);
    reset_n <= 0;
    mode_pins <= 3'h2;
    repeat (2) @(posedge clk);
    chk(oe[0], 0);
    reset_n <= 1;
    apb(0, 12'h024, 0);
    chk(rd, 32'h2);
    chk(owned, 1);
    chk(op_mode, 3'h2);
    $display("second reset test done");
    end_sim();
  end
endmodule
